// ===== core/port_io_pkg.sv
// Constants for the port three, four and five block.
// Assumes APB with 32-bit data, one register per aligned word.
package port_io_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_P3_DATA = 8'h00;
  localparam logic [7:0] OFS_P3_DIR = 8'h04;
  localparam logic [7:0] OFS_P3_OD = 8'h08;
  localparam logic [7:0] OFS_P4_DATA = 8'h0C;
  localparam logic [7:0] OFS_P4_DIR = 8'h10;
  localparam logic [7:0] OFS_P5_IN = 8'h14;
  localparam logic [7:0] OFS_SYSCFG = 8'h18;
  localparam logic [7:0] OFS_RSTCFG = 8'h1C;

  // ---------------------------------------------------------------
  // Reset values and masks
  // ---------------------------------------------------------------
  localparam logic [15:0] P3_DATA_RST = 16'h0000;
  localparam logic [15:0] P3_DIR_RST = 16'h0000;
  localparam logic [15:0] P3_OD_RST = 16'h0000;
  localparam logic [7:0] P4_DATA_RST = 8'h00;
  localparam logic [7:0] P4_DIR_RST = 8'h00;
  localparam logic [3:0] SYSCFG_RST = 4'h8;
  localparam logic [15:0] P3_PIN_MASK = 16'hBFFF;
  localparam logic [15:0] P3_OD_MASK = 16'h2FFF;
  localparam logic [15:0] P5_MASK = 16'hFC00;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int SYSCFG_SSP_EN = 0;
  localparam int SYSCFG_SYSTEM_CLOCK_OUTPUT_EN = 1;
  localparam int SYSCFG_BYTE_HIGH_DISABLE = 2;
  localparam int SYSCFG_WRITE_STROBE_CONFIG = 3;
  localparam int P3_BHE_BIT = 12;
  localparam int P3_CLK_BIT = 15;
  localparam int RSTCFG_SEG_LSB = 0;

  // Segment line count codes
  localparam logic [1:0] SEG_1MB = 2'b00;
  localparam logic [1:0] SEG_64KB = 2'b01;
  localparam logic [1:0] SEG_16MB = 2'b10;
  localparam logic [1:0] SEG_256KB = 2'b11;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_SETUP = 2'b01,
    BUS_ACCESS = 2'b11
  } bus_state_e;

endpackage : port_io_pkg

// ===== core/port_three_four_five_io.sv
// Port three (15-bit), port four (8-bit) and port five (6-bit input) logic.
// Assumes APB master on pclk, pads resolve pin level from oe_n signals.
//
// Summary of operation
// - Port three direction bit 0 makes input, 1 drives output.
// - Port three open-drain bit 0 push/pull, 1 open drain.
// - Lines 15, 14, 12 always push/pull.
// - Port three bit 14 stored but has no pin.
// - Alternate inputs of port three taken from synchronised input latch.
// - Alternate output pin value is peripheral output AND output latch.
// - Idle peripheral outputs rest high.
// - Clock output enable turns on line 15 driver by itself.
// - Byte-high pin is strobe after reset unless disabled by configuration.
// - Port four eight bits, general I/O where neither serial port nor segment lines take the pin.
// - Serial port enabled takes upper four port-four pins.
// - Port four direction bit 0 input, 1 output.
// - Segment lines become alternate function automatically after reset.
// - Segment count fixed at reset, readable in reset config register.
// - Code 01 no segment lines; code 11 drives A16-A17.
// - Code 00 drives A16-A19; code 10 drives A16-A23.
// - 16 MB mode drives A20-A23 regardless of serial port enable.
// - Segment outputs serve segmented cycles; other pins stay general I/O.
// - Port five input only, writes discarded.
// - Port five lines 10-15 feed timer inputs and read as data.
`timescale 1ns/100ps
module port_three_four_five_io
  import port_io_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Startup configuration, sampled at reset release
  input wire logic [1:0] startup_seg_code,
  // Port three pins
  input wire logic [15:0] p3_pin_in,
  output logic [15:0] p3_pin_out,
  output logic [15:0] p3_pin_oe_n,
  // Port four pins
  input wire logic [7:0] p4_pin_in,
  output logic [7:0] p4_pin_out,
  output logic [7:0] p4_pin_oe_n,
  // Port five pins
  input wire logic [15:0] p5_pin_in,
  // Peripheral alternate outputs, idle high
  input wire logic timer_six_toggle_out,
  input wire logic timer_three_toggle_out,
  input wire logic async_transmit_line,
  input wire logic system_clock_output,
  input wire logic sync_master_tx_slave_rx_out,
  input wire logic sync_master_rx_slave_tx_out,
  input wire logic sync_clock_out,
  input wire logic byte_high_strobe,
  input wire logic [7:0] segment_address,
  input wire logic serial_port_b_chip_enable1,
  input wire logic serial_port_b_chip_enable0,
  input wire logic serial_port_b_data_out,
  input wire logic serial_port_b_data_oe,
  input wire logic serial_port_b_clock,
  // Peripheral alternate inputs
  output logic [15:0] port_three_alt_in,
  output logic [7:0] port_four_alt_in,
  output logic [15:0] port_five_alt_in,
  output logic serial_port_b_enable
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    bus_state_e bus;
    logic [31:0] rdata;
    logic [15:0] p3_data;
    logic [15:0] p3_dir;
    logic [15:0] p3_od;
    logic [7:0] p4_data;
    logic [7:0] p4_dir;
    logic [3:0] syscfg;
    logic [1:0] seg_code;
    logic cfg_taken;
    logic [15:0] p3_s1;
    logic [15:0] p3_s2;
    logic [7:0] p4_s1;
    logic [7:0] p4_s2;
    logic [15:0] p5_s1;
    logic [15:0] p5_s2;
    logic [15:0] p3_out;
    logic [15:0] p3_oe_n;
    logic [7:0] p4_out;
    logic [7:0] p4_oe_n;
    logic pready;
    logic pslverr;
  } state_s;

  state_s st_ff;
  state_s nxt_st;

  // Number of segment lines per code
  function automatic logic [7:0] seg_mask(input logic [1:0] code);
    case (code)
      SEG_64KB: seg_mask = 8'h00;
      SEG_256KB: seg_mask = 8'h03;
      SEG_1MB: seg_mask = 8'h0F;
      SEG_16MB: seg_mask = 8'hFF;
      default: seg_mask = 8'h00;
    endcase
  endfunction : seg_mask

  logic [15:0] p3_alt_out;
  logic [15:0] p3_val;
  logic [15:0] p3_drive;
  logic [7:0] p4_seg;
  logic [7:0] p4_val;
  logic [7:0] p4_drive;
  logic ssp_en;
  logic bhe_on;
  logic acc;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    ssp_en = st_ff.syscfg[SYSCFG_SSP_EN];
    bhe_on = !st_ff.syscfg[SYSCFG_BYTE_HIGH_DISABLE] && st_ff.syscfg[SYSCFG_WRITE_STROBE_CONFIG];
    acc = psel && penable && !st_ff.pready;

    // Synchronisers
    nxt_st.p3_s1 = p3_pin_in & P3_PIN_MASK;
    nxt_st.p3_s2 = st_ff.p3_s1;
    nxt_st.p4_s1 = p4_pin_in;
    nxt_st.p4_s2 = st_ff.p4_s1;
    nxt_st.p5_s1 = p5_pin_in & P5_MASK;
    nxt_st.p5_s2 = st_ff.p5_s1;

    // Startup configuration caught after reset release
    if (!st_ff.cfg_taken) begin
      nxt_st.seg_code = startup_seg_code;
      nxt_st.cfg_taken = 1'b1;
    end

    // Bus slave, one wait state
    nxt_st.pready = 1'b0;
    nxt_st.pslverr = 1'b0;
    case (st_ff.bus)
      BUS_IDLE: begin
        if (psel && !penable) begin
          nxt_st.bus = BUS_SETUP;
        end
      end
      BUS_SETUP: begin
        if (acc) begin
          nxt_st.bus = BUS_ACCESS;
          nxt_st.pready = 1'b1;
          nxt_st.rdata = 32'h0000_0000;
          case (paddr)
            OFS_P3_DATA: nxt_st.rdata = {16'h0000, st_ff.p3_s2};
            OFS_P3_DIR: nxt_st.rdata = {16'h0000, st_ff.p3_dir};
            OFS_P3_OD: nxt_st.rdata = {16'h0000, st_ff.p3_od};
            OFS_P4_DATA: nxt_st.rdata = {24'h000000, st_ff.p4_s2};
            OFS_P4_DIR: nxt_st.rdata = {24'h000000, st_ff.p4_dir};
            OFS_P5_IN: nxt_st.rdata = {16'h0000, st_ff.p5_s2};
            OFS_SYSCFG: nxt_st.rdata = {28'h0000000, st_ff.syscfg};
            OFS_RSTCFG: nxt_st.rdata = {30'h0, st_ff.seg_code};
            default: nxt_st.pslverr = 1'b1;
          endcase
        end else if (!psel) begin
          nxt_st.bus = BUS_IDLE;
        end
      end
      BUS_ACCESS: begin
        // Write lands at the edge where the master sees pready
        if (psel && penable && pwrite) begin
          case (paddr)
            OFS_P3_DATA: nxt_st.p3_data = pwdata[15:0];
            OFS_P3_DIR: nxt_st.p3_dir = pwdata[15:0];
            OFS_P3_OD: nxt_st.p3_od = pwdata[15:0] & P3_OD_MASK;
            OFS_P4_DATA: nxt_st.p4_data = pwdata[7:0];
            OFS_P4_DIR: nxt_st.p4_dir = pwdata[7:0];
            OFS_SYSCFG: nxt_st.syscfg = pwdata[3:0];
            default: ;
          endcase
        end
        nxt_st.bus = (psel && !penable) ? BUS_SETUP : BUS_IDLE;
      end
      default: nxt_st.bus = BUS_IDLE;
    endcase

    // Port three alternate outputs, idle high
    p3_alt_out = 16'hFFFF;
    p3_alt_out[1] = timer_six_toggle_out;
    p3_alt_out[3] = timer_three_toggle_out;
    p3_alt_out[8] = sync_master_rx_slave_tx_out;
    p3_alt_out[9] = sync_master_tx_slave_rx_out;
    p3_alt_out[10] = async_transmit_line;
    p3_alt_out[13] = sync_clock_out;
    p3_alt_out[P3_CLK_BIT] = system_clock_output;
    p3_val = p3_alt_out & st_ff.p3_data;
    p3_drive = st_ff.p3_dir;
    if (bhe_on) begin
      p3_val[P3_BHE_BIT] = byte_high_strobe;
      p3_drive[P3_BHE_BIT] = 1'b1;
    end
    if (st_ff.syscfg[SYSCFG_SYSTEM_CLOCK_OUTPUT_EN]) begin
      p3_drive[P3_CLK_BIT] = 1'b1;
    end
    p3_drive = p3_drive & P3_PIN_MASK;
    nxt_st.p3_out = p3_val & P3_PIN_MASK;
    // Open drain releases the pin on a high level
    nxt_st.p3_oe_n = ~(p3_drive & ~(st_ff.p3_od & P3_OD_MASK & p3_val));

    // Port four
    p4_val = st_ff.p4_data;
    p4_drive = st_ff.p4_dir;
    if (ssp_en) begin
      p4_val[7:4] = {serial_port_b_clock, serial_port_b_data_out,
                     serial_port_b_chip_enable0, serial_port_b_chip_enable1};
      p4_drive[7:4] = {1'b1, serial_port_b_data_oe, 2'b11};
    end
    p4_seg = seg_mask(st_ff.seg_code);
    p4_val = (p4_val & ~p4_seg) | (segment_address & p4_seg);
    p4_drive = p4_drive | p4_seg;
    nxt_st.p4_out = p4_val;
    nxt_st.p4_oe_n = ~p4_drive;
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '{bus: BUS_IDLE, rdata: 32'h0000_0000, p3_data: P3_DATA_RST,
                 p3_dir: P3_DIR_RST, p3_od: P3_OD_RST, p4_data: P4_DATA_RST,
                 p4_dir: P4_DIR_RST, syscfg: SYSCFG_RST, seg_code: SEG_64KB,
                 cfg_taken: 1'b0, p3_s1: 16'h0000, p3_s2: 16'h0000,
                 p4_s1: 8'h00, p4_s2: 8'h00, p5_s1: 16'h0000, p5_s2: 16'h0000,
                 p3_out: 16'h0000, p3_oe_n: 16'hFFFF, p4_out: 8'h00,
                 p4_oe_n: 8'hFF, pready: 1'b0, pslverr: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata = st_ff.rdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign p3_pin_out = st_ff.p3_out;
  assign p3_pin_oe_n = st_ff.p3_oe_n;
  assign p4_pin_out = st_ff.p4_out;
  assign p4_pin_oe_n = st_ff.p4_oe_n;
  assign port_three_alt_in = st_ff.p3_s2;
  assign port_four_alt_in = st_ff.p4_s2;
  assign port_five_alt_in = st_ff.p5_s2;
  assign serial_port_b_enable = st_ff.syscfg[SYSCFG_SSP_EN];

endmodule : port_three_four_five_io

// ===== dv/port_io_asserts.sv
// Checker for the port three, four and five block.
// Assumes it is bound into port_three_four_five_io.
`timescale 1ns/100ps
module port_io_asserts
  import port_io_pkg::*;
(
  // Clock, reset and bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and peripherals
  input wire logic [1:0] startup_seg_code,
  input wire logic [15:0] p3_pin_in,
  input wire logic [15:0] p3_pin_out,
  input wire logic [15:0] p3_pin_oe_n,
  input wire logic [7:0] p4_pin_out,
  input wire logic [7:0] p4_pin_oe_n,
  input wire logic [15:0] p5_pin_in,
  input wire logic byte_high_strobe,
  input wire logic [7:0] segment_address,
  input wire logic serial_port_b_chip_enable1,
  input wire logic serial_port_b_chip_enable0,
  input wire logic [15:0] port_three_alt_in,
  input wire logic [15:0] port_five_alt_in
);
  // ----------------
  // Shadow state
  // ----------------
  typedef struct packed {
    logic [1:0] age;
    logic [3:0] cfg;
    logic [1:0] seg;
    logic [7:0] mask;
  } shadow_s;
  shadow_s sh_ff;
  shadow_s nxt_sh;
  always_comb begin
    nxt_sh = sh_ff;
    if (sh_ff.age != 2'h3) nxt_sh.age = sh_ff.age + 2'h1;
    if (sh_ff.age == 2'h0) nxt_sh.seg = startup_seg_code;
    if (psel && penable && pready && pwrite && !pslverr && paddr == OFS_SYSCFG) begin
      nxt_sh.cfg = pwdata[3:0];
    end
    case (sh_ff.seg)
      SEG_1MB: nxt_sh.mask = 8'h0F;
      SEG_16MB: nxt_sh.mask = 8'hFF;
      SEG_256KB: nxt_sh.mask = 8'h03;
      default: nxt_sh.mask = 8'h00;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_ff <= {2'h0, 4'h8, SEG_64KB, 8'h00};
    end else begin
      sh_ff <= nxt_sh;
    end
  end
  // ----------------
  // Assertions
  // ----------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  chk_apb_answer: assert property (s_setup ##1 s_access |=> pready ##1 !pready)
    else $error("bus answer late or not a pulse");
  chk_p5_sync: assert property (sh_ff.age[1] |->
    port_five_alt_in[15:10] == $past(p5_pin_in[15:10], 2))
    else $error("port five input path wrong");
  chk_p3_sync: assert property (sh_ff.age[1] |->
    port_three_alt_in[13:0] == $past(p3_pin_in[13:0], 2))
    else $error("port three input path wrong");
  chk_bit14_nopin: assert property (p3_pin_oe_n[14])
    else $error("line without pin driven");
  chk_system_clock_output_drive: assert property (sh_ff.age != 2'h0 && $past(sh_ff.cfg[1]) |->
    !p3_pin_oe_n[15])
    else $error("clock output not driven");
  chk_strobe_auto: assert property (sh_ff.age != 2'h0 && $past(sh_ff.cfg[3:2]) == 2'b10 |->
    !p3_pin_oe_n[12] && p3_pin_out[12] == $past(byte_high_strobe))
    else $error("strobe line wrong");
  chk_seg_lines: assert property (sh_ff.age != 2'h0 |->
    (p4_pin_oe_n & sh_ff.mask) == 8'h00 &&
    ((p4_pin_out ^ $past(segment_address)) & sh_ff.mask) == 8'h00)
    else $error("segment lines wrong");
  chk_ssp_pins: assert property (sh_ff.age != 2'h0 && $past(sh_ff.cfg[0]) && !sh_ff.mask[4] |->
    p4_pin_oe_n[5:4] == 2'b00 &&
    p4_pin_out[5:4] == $past({serial_port_b_chip_enable0, serial_port_b_chip_enable1}))
    else $error("serial port chip enables wrong");
endmodule : port_io_asserts
bind port_three_four_five_io port_io_asserts port_io_asserts_i (.*);

// ===== dv/port_pins_model.sv
// Far side: package pins and the peripherals' alternate outputs.
// Assumes the bench supplies the external pin levels.
`timescale 1ns/100ps
module port_pins_model (
  // Block pin outputs
  input wire logic [15:0] p3_out,
  input wire logic [15:0] p3_oe_n,
  input wire logic [7:0] p4_out,
  input wire logic [7:0] p4_oe_n,
  // External levels and peripheral activity
  input wire logic [15:0] p3_ext,
  input wire logic [7:0] p4_ext,
  input wire logic per_act,
  input wire logic [6:0] per_val,
  // Pin levels and peripheral outputs
  output logic [15:0] p3_lvl,
  output logic [7:0] p4_lvl,
  output logic [6:0] per_out
);
  // Undriven lines take the external level
  assign p3_lvl = (p3_out & ~p3_oe_n) | (p3_ext & p3_oe_n);
  assign p4_lvl = (p4_out & ~p4_oe_n) | (p4_ext & p4_oe_n);
  // Unused alternate outputs rest high
  assign per_out = per_act ? per_val : 7'h7F;
endmodule : port_pins_model

// ===== dv/port_three_four_five_io_tb.sv
// Self-checking bench for the port three, four and five block.
// Assumes the pin model and the checker are compiled with it.
`timescale 1ns/100ps
module port_three_four_five_io_tb;
  import port_io_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slv;
  logic [7:0] paddr, p4_out, p4_oe_n, p4_lvl, p4_ext, seg_addr, d4, dir4;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] seg_code;
  logic [15:0] p3_out, p3_oe_n, p3_lvl, p3_ext, p5_in, d3, dir3, od3, e3;
  logic [6:0] per_out, per_val;
  logic per_act, bhs, ce1, ce0, sdo, sdoe, sclk, sspe;
  logic [7:0] p4_alt;
  int errors, num_checks, cyc;
  port_three_four_five_io port_three_four_five_io_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .startup_seg_code(seg_code), .p3_pin_in(p3_lvl), .p3_pin_out(p3_out),
    .p3_pin_oe_n(p3_oe_n), .p4_pin_in(p4_lvl), .p4_pin_out(p4_out), .p4_pin_oe_n(p4_oe_n),
    .p5_pin_in(p5_in), .timer_six_toggle_out(per_out[0]),
    .timer_three_toggle_out(per_out[1]), .async_transmit_line(per_out[2]),
    .system_clock_output(per_out[3]), .sync_master_tx_slave_rx_out(per_out[4]),
    .sync_master_rx_slave_tx_out(per_out[5]), .sync_clock_out(per_out[6]),
    .byte_high_strobe(bhs), .segment_address(seg_addr), .serial_port_b_chip_enable1(ce1),
    .serial_port_b_chip_enable0(ce0), .serial_port_b_data_out(sdo),
    .serial_port_b_data_oe(sdoe), .serial_port_b_clock(sclk), .port_three_alt_in(),
    .port_four_alt_in(p4_alt), .port_five_alt_in(), .serial_port_b_enable(sspe));
  port_pins_model port_pins_model_i (.p3_out, .p3_oe_n, .p4_out, .p4_oe_n, .p3_ext,
    .p4_ext, .per_act, .per_val, .p3_lvl, .p4_lvl, .per_out);
  // ----------------
  // Helpers
  // ----------------
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    {bhs, seg_addr, ce1, ce0, sdo, sdoe, sclk} <= 14'($urandom);
    cyc++;
    if (cyc == 5000) begin
      errors++;
      summarize();
    end
  end
  function automatic logic [7:0] seg_mask(input logic [1:0] c);
    return (c == SEG_64KB) ? 8'h00 : (c == SEG_256KB) ? 8'h03 : (c == SEG_1MB) ? 8'h0F : 8'hFF;
  endfunction : seg_mask
  function automatic logic [15:0] oe3(input logic [15:0] d, dir, od);
    return ~dir | (od & d & P3_OD_MASK) | 16'h4000;
  endfunction : oe3
  task chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task rst(input logic [1:0] c);
    presetn <= 1'b0;
    seg_code <= c;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    #1;
  endtask : rst
  task summarize;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize
  // ----------------
  // Scenarios
  // ----------------
  initial begin
    void'($urandom(32'h7a434dcd));
    {psel, penable, pwrite, paddr, pwdata, per_act, per_val, p3_ext, p4_ext, p5_in} = '0;
    {errors, num_checks, cyc, presetn, seg_code} = '0;
    for (int c = 0; c < 4; c++) begin
      rst(2'(c));
      chk("strobe oe", p3_oe_n[12], 1'b0);
      chk("seg oe", p4_oe_n, 8'(~seg_mask(2'(c))));
      apb(1'b0, OFS_RSTCFG, 32'h0);
      chk("seg code", rd, 32'(c));
      apb(1'b0, OFS_SYSCFG, 32'h0);
      chk("cfg reset", rd, 32'h8);
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped", slv, 1'b1);
      apb(1'b1, OFS_SYSCFG, 32'h9);
      repeat (3) @(posedge pclk);
      #1;
      chk("ssp enable", sspe, 1'b1);
      if (c == 2) chk("seg over ssp", p4_oe_n, 8'h00);
    end
    rst(SEG_64KB);
    apb(1'b1, OFS_SYSCFG, 32'h4);
    repeat (8) begin
      {d3, dir3, od3, d4, dir4} = 64'({$urandom, $urandom});
      p3_ext <= 16'($urandom);
      p4_ext <= 8'($urandom);
      p5_in <= 16'($urandom);
      apb(1'b1, OFS_P3_DATA, 32'(d3));
      apb(1'b1, OFS_P3_DIR, 32'(dir3));
      apb(1'b1, OFS_P3_OD, 32'(od3));
      apb(1'b1, OFS_P4_DATA, 32'(d4));
      apb(1'b1, OFS_P4_DIR, 32'(dir4));
      apb(1'b1, OFS_P5_IN, 32'hFFFF);
      chk("p5 write err", slv, 1'b0);
      e3 = oe3(d3, dir3, od3);
      chk("p3 oe", p3_oe_n, e3);
      chk("p3 out", p3_out & ~e3, d3 & ~e3);
      chk("p4 oe", p4_oe_n, 8'(~dir4));
      apb(1'b0, OFS_P3_OD, 32'h0);
      chk("p3 od rd", rd, 32'(od3 & P3_OD_MASK));
      apb(1'b0, OFS_P3_DATA, 32'h0);
      chk("p3 pins", rd & P3_PIN_MASK, ((d3 & ~e3) | (p3_ext & e3)) & P3_PIN_MASK);
      apb(1'b0, OFS_P4_DATA, 32'h0);
      chk("p4 pins", rd, 32'((d4 & dir4) | (p4_ext & ~dir4)));
      chk("p4 alt in", p4_alt, 8'((d4 & dir4) | (p4_ext & ~dir4)));
      apb(1'b0, OFS_P5_IN, 32'h0);
      chk("p5 pins", rd & P5_MASK, p5_in & P5_MASK);
    end
    for (int l = 0; l < 2; l++) begin
      per_act <= 1'b1;
      per_val <= 7'($urandom);
      apb(1'b1, OFS_P3_DIR, 32'hFFFF);
      apb(1'b1, OFS_P3_OD, 32'h0);
      apb(1'b1, OFS_P3_DATA, l ? 32'hFFFF : 32'h0);
      repeat (3) @(posedge pclk);
      #1;
      chk("alt out", {p3_out[10], p3_out[3], p3_out[1]}, per_val[2:0] & {3{l[0]}});
    end
    apb(1'b1, OFS_P3_DIR, 32'h0);
    apb(1'b1, OFS_SYSCFG, 32'h6);
    repeat (3) @(posedge pclk);
    #1;
    chk("system_clock_output oe", p3_oe_n[15], 1'b0);
    summarize();
  end
endmodule : port_three_four_five_io_tb
